// [afe_ctl_pkg.sv]
package afe_ctl_pkg;

    // ********************************************************
    // serial word layout
    // ********************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 28;
    localparam logic [5:0] ADDR_LAST_BIT = 6'h0B;
    localparam logic [5:0] DATA_LAST_BIT = 6'h1B;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] OFS_FRONTEND = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT   = 12'h001;
    localparam logic [ADDR_W-1:0] OFS_SAMPLER  = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_AMPGAIN  = 12'h005;

    // ********************************************************
    // field positions and widths
    // ********************************************************
    localparam int POS_POWER     = 0;
    localparam int POWER_W       = 2;
    localparam int POS_CLAMP_ON  = 2;
    localparam int POS_SETTLE    = 3;
    localparam int POS_QUICK     = 4;
    localparam int POS_BLANK_LVL = 5;
    localparam int POS_DC_BYP    = 6;
    localparam int POS_SUB_SEL   = 11;
    localparam int SUB_SEL_W     = 4;
    localparam int POS_TRISTATE  = 0;
    localparam int POS_LATCH_BYP = 1;
    localparam int SAMPLER_W     = 2;
    localparam int AMP_W         = 10;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [DATA_W-1:0] RST_FRONTEND = 28'h0000007;
    localparam logic [DATA_W-1:0] RST_OUTPUT   = 28'h0000008;
    localparam logic [DATA_W-1:0] RST_SAMPLER  = 28'h0000001;
    localparam logic [DATA_W-1:0] RST_AMPGAIN  = 28'h0000000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_req_s;

endpackage

// [serial_word_rx.sv]
`timescale 1ns/100ps
module serial_word_rx
    import afe_ctl_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_b_i,
    input  wire logic    ser_clk_i,
    input  wire logic    ser_data_i,
    input  wire logic    ser_load_b_i,
    output logic         wr_valid_o,
    output wr_req_s      wr_req_o
);

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    logic [2:0]        s1_r;
    logic [2:0]        s2_r;
    logic              sclk_d_r;
    logic              addr_phase_r;
    logic [5:0]        cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_sh_r;
    logic              rise;
    logic              active;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r     <= 3'h1;
            s2_r     <= 3'h1;
            sclk_d_r <= 1'b0;
        end else begin
            s1_r     <= {ser_clk_i, ser_data_i, ser_load_b_i};
            s2_r     <= s1_r;
            sclk_d_r <= s2_r[2];
        end
    end

    assign rise   = s2_r[2] & ~sclk_d_r;
    assign active = ~s2_r[0];

    // ********************************************************
    // shift engine
    // ********************************************************
    // lsb-first word assembly
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_phase_r <= 1'b1;
            cnt_r        <= 6'h00;
            addr_r       <= '0;
            data_sh_r    <= '0;
        end else if (!active) begin
            addr_phase_r <= 1'b1;
            cnt_r        <= 6'h00;
        end else if (rise) begin
            if (addr_phase_r) begin
                addr_r <= {s2_r[1], addr_r[ADDR_W-1:1]};
                if (cnt_r == ADDR_LAST_BIT) begin
                    addr_phase_r <= 1'b0;
                    cnt_r        <= 6'h00;
                end else begin
                    cnt_r <= cnt_r + 6'h01;
                end
            end else begin
                data_sh_r <= {s2_r[1], data_sh_r[DATA_W-1:1]};
                if (cnt_r == DATA_LAST_BIT) begin
                    // auto-increment for continuous writes
                    cnt_r  <= 6'h00;
                    addr_r <= addr_r + 12'h001;
                end else begin
                    cnt_r <= cnt_r + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_valid_o <= 1'b0;
            wr_req_o   <= '0;
        end else begin
            wr_valid_o <= active & rise & ~addr_phase_r & (cnt_r == DATA_LAST_BIT);
            if (active && rise && !addr_phase_r && cnt_r == DATA_LAST_BIT) begin
                wr_req_o.addr <= addr_r;
                wr_req_o.data <= {s2_r[1], data_sh_r[DATA_W-1:1]};
            end
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    chk_full_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_valid_o |-> $past(cnt_r) == DATA_LAST_BIT && !$past(addr_phase_r))
        else $error("write issued before the 28th data bit");

endmodule

// [afe_control_register_bank.sv]
`timescale 1ns/100ps
// Contract
// - bit 2 of 0x00 enables the black clamp loop, resets to 1
// - bit 3 of 0x00 selects fast clamp settling, resets to 0
// - bit 4 of 0x00 requests very fast clamping on each amplifier gain change
// - during blanking outputs show zero, or clamp level when bit 5 set
// - bit 6 of 0x00 bypasses dc restore during blanking
// - bits 14:11 of 0x00 pick substrate output source, codes 0 to 7
// - same field, codes 8 to 15 pick the remaining sources
// - bit 0 of 0x01 set places the data outputs in high impedance
// - bit 1 of 0x01 clear registers outputs, set makes latch transparent
// - ten-bit amplifier gain at 0x05, applied at sync fall
// - writes are 12-bit address plus 28-bit data, lsb first; short dropped
// - immediate registers update on the final data bit
// - frame registers wait pending until the next vertical sync fall
module afe_control_register_bank
    import afe_ctl_pkg::*;
#(
    parameter int SAMPLE_W = 12
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 ser_clk_i,
    input  wire logic                 ser_data_i,
    input  wire logic                 ser_load_b_i,
    input  wire logic                 vertical_sync_i,
    input  wire logic [15:0]          sub_sources_i,
    input  wire logic [SAMPLE_W-1:0]  adc_data_i,
    input  wire logic [SAMPLE_W-1:0]  clamp_level_i,
    input  wire logic                 pixel_blanking_i,
    output logic [POWER_W-1:0]        power_state_o,
    output logic                      black_clamp_on_o,
    output logic                      clamp_settling_fast_o,
    output logic                      quick_clamp_o,
    output logic                      dc_restore_en_o,
    output logic                      substrate_control_out_o,
    output logic [SAMPLE_W-1:0]       dout_o,
    output logic                      dout_oe_o,
    output logic [SAMPLE_W-1:0]       dout_blank_o,
    output logic [SAMPLER_W-1:0]      sampler_gain_o,
    output logic [AMP_W-1:0]          amplifier_gain_o
);

    // ********************************************************
    // serial write port
    // ********************************************************
    logic              wr_valid;
    wr_req_s           wr_req;
    logic [DATA_W-1:0] fe_r;
    logic [DATA_W-1:0] out_r;
    logic [DATA_W-1:0] sampler_pend_r;
    logic [DATA_W-1:0] amp_pend_r;
    logic [DATA_W-1:0] sampler_act_r;
    logic [DATA_W-1:0] amp_act_r;
    logic              vs1_r;
    logic              vs2_r;
    logic              vs_d_r;
    logic              sync_fall;
    logic [SAMPLE_W-1:0] dout_pre;
    logic [SAMPLE_W-1:0] dout_q_r;
    logic              sub_r;
    logic              quick_r;

    serial_word_rx u_rx (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .ser_clk_i    (ser_clk_i),
        .ser_data_i   (ser_data_i),
        .ser_load_b_i (ser_load_b_i),
        .wr_valid_o   (wr_valid),
        .wr_req_o     (wr_req)
    );

    function automatic logic hit(input wr_req_s req, input logic [ADDR_W-1:0] ofs);
        hit = (req.addr == ofs);
    endfunction

    // ********************************************************
    // immediate registers
    // ********************************************************
    // commit on last bit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fe_r  <= RST_FRONTEND;
            out_r <= RST_OUTPUT;
        end else if (wr_valid) begin
            if (hit(wr_req, OFS_FRONTEND)) begin
                fe_r <= wr_req.data;
            end
            if (hit(wr_req, OFS_OUTPUT)) begin
                out_r <= wr_req.data;
            end
        end
    end

    // ********************************************************
    // frame registers
    // ********************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vs1_r  <= 1'b0;
            vs2_r  <= 1'b0;
            vs_d_r <= 1'b0;
        end else begin
            vs1_r  <= vertical_sync_i;
            vs2_r  <= vs1_r;
            vs_d_r <= vs2_r;
        end
    end

    assign sync_fall = vs_d_r & ~vs2_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sampler_pend_r <= RST_SAMPLER;
            amp_pend_r     <= RST_AMPGAIN;
        end else if (wr_valid) begin
            if (hit(wr_req, OFS_SAMPLER)) begin
                sampler_pend_r <= wr_req.data;
            end
            if (hit(wr_req, OFS_AMPGAIN)) begin
                amp_pend_r <= wr_req.data;
            end
        end
    end

    // apply at sync fall; a write in the same cycle waits one field
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sampler_act_r <= RST_SAMPLER;
            amp_act_r     <= RST_AMPGAIN;
        end else if (sync_fall) begin
            sampler_act_r <= sampler_pend_r;
            amp_act_r     <= amp_pend_r;
        end
    end

    assign sampler_gain_o   = sampler_act_r[SAMPLER_W-1:0];
    assign amplifier_gain_o = amp_act_r[AMP_W-1:0];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quick_r <= 1'b0;
        end else begin
            quick_r <= sync_fall & fe_r[POS_QUICK]
                       & (amp_pend_r[AMP_W-1:0] != amp_act_r[AMP_W-1:0]);
        end
    end

    assign quick_clamp_o = quick_r;

    // ********************************************************
    // front-end controls
    // ********************************************************
    // power state field
    assign power_state_o         = fe_r[POS_POWER +: POWER_W];
    assign black_clamp_on_o      = fe_r[POS_CLAMP_ON];
    assign clamp_settling_fast_o = fe_r[POS_SETTLE];
    assign dc_restore_en_o       = ~(pixel_blanking_i & fe_r[POS_DC_BYP]);

    // substrate source mux, code indexes source bit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sub_r <= 1'b0;
        end else begin
            sub_r <= sub_sources_i[fe_r[POS_SUB_SEL +: SUB_SEL_W]];
        end
    end

    assign substrate_control_out_o = sub_r;

    // ********************************************************
    // data output path
    // ********************************************************
    // blanking value
    assign dout_blank_o = fe_r[POS_BLANK_LVL] ? clamp_level_i : '0;
    assign dout_pre     = pixel_blanking_i ? dout_blank_o : adc_data_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_q_r <= '0;
        end else begin
            dout_q_r <= dout_pre;
        end
    end

    // transparent latch trades a cycle of latency for glitch exposure
    assign dout_o    = out_r[POS_LATCH_BYP] ? dout_pre : dout_q_r;
    assign dout_oe_o = ~out_r[POS_TRISTATE];

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_imm_write: assert property (
        wr_valid && wr_req.addr == OFS_FRONTEND |=> fe_r == $past(wr_req.data))
        else $error("front-end register not updated on last bit");
    chk_frame_hold: assert property (
        !sync_fall |=> sampler_gain_o == $past(sampler_gain_o)
                     && amplifier_gain_o == $past(amplifier_gain_o))
        else $error("frame register changed outside sync fall");
    chk_sampler_apply: assert property (
        sync_fall |=> sampler_gain_o == $past(sampler_pend_r[SAMPLER_W-1:0]))
        else $error("sampler gain not applied at sync fall");
    chk_amp_apply: assert property (
        sync_fall |=> amplifier_gain_o == $past(amp_pend_r[AMP_W-1:0]))
        else $error("amplifier gain not applied at sync fall");
    chk_quick_clamp: assert property (
        quick_clamp_o |-> $past(fe_r[POS_QUICK]) && $changed(amplifier_gain_o))
        else $error("quick clamp without gain change");
    chk_blank_zero: assert property (
        pixel_blanking_i && !fe_r[POS_BLANK_LVL] && out_r[POS_LATCH_BYP] |-> dout_o == '0)
        else $error("blanked output not zero");
    chk_latch_reg: assert property (
        !out_r[POS_LATCH_BYP] && !pixel_blanking_i ##1 !out_r[POS_LATCH_BYP]
        |-> dout_o == $past(adc_data_i))
        else $error("registered output wrong");
    chk_tristate: assert property (
        wr_valid && wr_req.addr == OFS_OUTPUT && wr_req.data[POS_TRISTATE] |=> !dout_oe_o)
        else $error("outputs still driven after disable");
    chk_sub_mux: assert property (
        ##1 substrate_control_out_o == $past(sub_sources_i[fe_r[POS_SUB_SEL +: SUB_SEL_W]]))
        else $error("substrate output source wrong");
    chk_dc_bypass: assert property (
        pixel_blanking_i && fe_r[POS_DC_BYP] |-> !dc_restore_en_o)
        else $error("dc restore not bypassed");

    cov_frame_write: cover property (wr_valid && wr_req.addr == OFS_AMPGAIN ##[1:1000] sync_fall);
    cov_quick: cover property (quick_clamp_o);
    cov_tristate: cover property (!dout_oe_o);
    cov_blank_level: cover property (pixel_blanking_i && fe_r[POS_BLANK_LVL]);

endmodule

// [afe_host_model.sv]
`timescale 1ns/100ps
// ****************************************
// host side of the three-wire write port
// ****************************************
module afe_host_model (
    input  wire logic clk_i,
    output logic      ser_clk_o,
    output logic      ser_data_o,
    output logic      ser_load_b_o
);
    // clock rests low between frames
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b1;
        ser_load_b_o = 1'b1;
    end

    task automatic bit_out(input logic b);
        @(negedge clk_i);
        ser_data_o = b;
        ser_clk_o = 1'b0;
        repeat (4) @(negedge clk_i);
        ser_clk_o = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic send(input logic [11:0] a, input logic [55:0] d, input int n);
        @(negedge clk_i);
        ser_load_b_o = 1'b0;
        for (int i = 0; i < 12; i++) begin
            bit_out(a[i]);
        end
        for (int i = 0; i < n; i++) begin
            bit_out(d[i]);
        end
        @(negedge clk_i);
        ser_clk_o = 1'b0;
        repeat (4) @(negedge clk_i);
        ser_load_b_o = 1'b1;
        // released line must not look like held data
        ser_data_o = ~ser_data_o;
    endtask
endmodule

// [afe_control_register_bank_test.sv]
`timescale 1ns/100ps
module afe_control_register_bank_test;
    import afe_ctl_pkg::*;
    logic        clk_i, rst_b_i, sclk, sdat, sload_b;
    logic        vertical_sync_i, pixel_blanking_i;
    logic [15:0] sub_sources_i;
    logic [11:0] adc_data_i, clamp_level_i, dout_o, dout_blank_o, old;
    logic [1:0]  power_state_o, sampler_gain_o, sg;
    logic        black_clamp_on_o, clamp_settling_fast_o, quick_clamp_o;
    logic        dc_restore_en_o, substrate_control_out_o, dout_oe_o;
    logic [9:0]  amplifier_gain_o, ag;
    logic [31:0] seed, r;
    logic [27:0] fe;
    int          fail_count, num_checks, qc_cnt;

    afe_host_model host (.clk_i(clk_i), .ser_clk_o(sclk), .ser_data_o(sdat),
                         .ser_load_b_o(sload_b));
    afe_control_register_bank DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ser_clk_i(sclk), .ser_data_i(sdat),
        .ser_load_b_i(sload_b), .vertical_sync_i(vertical_sync_i),
        .sub_sources_i(sub_sources_i), .adc_data_i(adc_data_i),
        .clamp_level_i(clamp_level_i), .pixel_blanking_i(pixel_blanking_i),
        .power_state_o(power_state_o), .black_clamp_on_o(black_clamp_on_o),
        .clamp_settling_fast_o(clamp_settling_fast_o), .quick_clamp_o(quick_clamp_o),
        .dc_restore_en_o(dc_restore_en_o),
        .substrate_control_out_o(substrate_control_out_o), .dout_o(dout_o),
        .dout_oe_o(dout_oe_o), .dout_blank_o(dout_blank_o),
        .sampler_gain_o(sampler_gain_o), .amplifier_gain_o(amplifier_gain_o));

    always #25 clk_i = ~clk_i;
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk_i) if (quick_clamp_o === 1'b1) qc_cnt++;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] exp_blank(logic [27:0] f, logic [11:0] lvl);
        return f[POS_BLANK_LVL] ? lvl : 12'h000;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(negedge clk_i);
    endtask
    task automatic check_fe();
        r = rnd();
        chk(power_state_o, fe[1:0], "power");
        chk(black_clamp_on_o, fe[POS_CLAMP_ON], "clamp on");
        chk(clamp_settling_fast_o, fe[POS_SETTLE], "fast");
        pixel_blanking_i = r[16];
        clamp_level_i = r[31:20];
        sub_sources_i = r[15:0];
        #1;
        chk(dc_restore_en_o, !(r[16] && fe[POS_DC_BYP]), "dc");
        chk(dout_blank_o, exp_blank(fe, r[31:20]), "blank");
        repeat (2) @(negedge clk_i);
        chk(substrate_control_out_o, r[fe[14:11]], "sub");
    endtask
    task automatic wr_fe(input logic [27:0] v);
        host.send(OFS_FRONTEND, {28'h0, v}, 28);
        fe = v;
        settle();
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        clk_i = 1'b0;
        rst_b_i = 1'b0;
        vertical_sync_i = 1'b0;
        pixel_blanking_i = 1'b0;
        sub_sources_i = 16'h0000;
        adc_data_i = 12'h000;
        clamp_level_i = 12'h000;
        seed = 32'h0000000E;
        fail_count = 0;
        num_checks = 0;
        qc_cnt = 0;
        repeat (16) @(negedge clk_i);
        rst_b_i = 1'b1;
        fe = RST_FRONTEND;
        sg = 2'h1;
        ag = 10'h000;
        check_fe();
        chk(dout_oe_o, 1'b1, "oe reset");
        chk(sampler_gain_o, sg, "sg reset");
        chk(amplifier_gain_o, ag, "ag reset");
        for (int c = 0; c < 16; c++) begin
            r = rnd();
            wr_fe({13'h0000, c[3:0], 4'h0, r[6:0]});
            check_fe();
        end
        host.send(OFS_FRONTEND, {28'h0, ~fe}, 20);
        settle();
        check_fe();
        host.send(12'h002, {28'h0, ~fe}, 28);
        settle();
        check_fe();
        // random blanking from the last check must not reach the data path
        pixel_blanking_i = 1'b0;
        for (int m = 3; m >= 0; m--) begin
            host.send(OFS_OUTPUT, {52'h0, 2'b10, m[1:0]}, 28);
            settle();
            chk(dout_oe_o, !m[0], "oe");
            old = adc_data_i;
            r = rnd();
            adc_data_i = r[11:0];
            #1;
            chk(dout_o, m[1] ? r[11:0] : old, "latch");
            @(posedge clk_i);
            #1;
            chk(dout_o, r[11:0], "dout");
            @(negedge clk_i);
            pixel_blanking_i = 1'b1;
            @(posedge clk_i);
            #1;
            chk(dout_o, exp_blank(fe, clamp_level_i), "blank out");
            @(negedge clk_i);
            pixel_blanking_i = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            fe[POS_QUICK] = k[0];
            wr_fe(fe);
            r = rnd();
            if (k == 3) r[11:2] = ag;
            host.send(OFS_SAMPLER, {18'h0, r[11:2], 26'h0, r[1:0]}, 56);
            settle();
            chk(sampler_gain_o, sg, "sg pending");
            chk(amplifier_gain_o, ag, "ag pending");
            qc_cnt = 0;
            @(negedge clk_i);
            vertical_sync_i = 1'b1;
            repeat (4) @(negedge clk_i);
            vertical_sync_i = 1'b0;
            repeat (8) @(negedge clk_i);
            chk(sampler_gain_o, r[1:0], "sg");
            chk(amplifier_gain_o, r[11:2], "ag");
            chk(qc_cnt, k[0] && (r[11:2] != ag), "quick");
            sg = r[1:0];
            ag = r[11:2];
        end
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule
